// ===== rtl/pid_step.sv
module pid_step #(
	parameter logic signed [pwr_ctrl_pkg::PID_W-1:0] KP = pwr_ctrl_pkg::FREQ_KP
) (
	input  wire logic                                  pclk,
	input  wire logic                                  presetn,
	input  wire logic                                  err_vld,
	input  wire logic signed [pwr_ctrl_pkg::PID_W-1:0] err,
	output logic                                       out_vld,
	output logic signed [pwr_ctrl_pkg::PID_W-1:0]      out
);
	import pwr_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// Proportional term only; integral and derivative gains are zero.
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                    vld;
		logic signed [PID_W-1:0] out;
	} pid_state_t;

	pid_state_t q, d;
	logic signed [2*PID_W-1:0] prod;

	always_comb begin
		prod  = err * KP;
		d.vld = err_vld;
		d.out = q.out;
		if (err_vld) begin
			if (prod > PID_OUTPUT_LIMIT) begin
				d.out = PID_OUTPUT_LIMIT;
			end else if (prod < -PID_OUTPUT_LIMIT) begin
				d.out = -PID_OUTPUT_LIMIT;
			end else begin
				d.out = prod[PID_W-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_vld = q.vld;
	assign out     = q.out;

	property p_pid_clamp;
		@(posedge pclk) disable iff (!presetn)
		out_vld |-> (out <= PID_OUTPUT_LIMIT) && (out >= -PID_OUTPUT_LIMIT);
	endproperty
	a_pid_clamp: assert property (p_pid_clamp) else $error("pid output beyond limit");

	property p_pid_gain;
		@(posedge pclk) disable iff (!presetn)
		(err_vld && err < 18'sh00100 && err > -18'sh00100) |=> (out == $past(err) * KP);
	endproperty
	a_pid_gain: assert property (p_pid_gain) else $error("pid gain wrong");

endmodule

// ===== rtl/pwr_ctrl_pkg.sv
package pwr_ctrl_pkg;

	// ----------------------------------------------------------------
	// Clock and widths
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ  = 32'h0131_2D00;
	localparam int unsigned ACC_W   = 25;
	localparam int unsigned FREQ_W  = 18;
	localparam int unsigned DUTY_W  = 10;
	localparam int unsigned CUR_W   = 16;
	localparam int unsigned PID_W   = 18;
	localparam int unsigned TMR_W   = 24;
	localparam int unsigned ADDR_W  = 8;

	// ----------------------------------------------------------------
	// Operating points, frequency in Hz, duty in steps of 0.1 percent
	// ----------------------------------------------------------------
	localparam logic [FREQ_W-1:0] FREQ_MIN_HZ  = 18'h1ADB0;
	localparam logic [FREQ_W-1:0] FREQ_MAX_HZ  = 18'h320C8;
	localparam logic [FREQ_W-1:0] FREQ_PING_HZ = 18'h1FBD0;
	localparam logic [DUTY_W-1:0] DUTY_MIN     = 10'h014;
	localparam logic [DUTY_W-1:0] DUTY_MAX     = 10'h1F4;
	localparam logic [DUTY_W-1:0] DUTY_PING    = 10'h0FA;
	localparam logic [DUTY_W-1:0] DUTY_STEP    = 10'h032;
	localparam logic [ACC_W-1:0]  DUTY_UNIT_CYC = ACC_W'(CLK_HZ / 32'h0000_03E8);
	localparam logic [ACC_W-1:0]  ACC_WRAP      = ACC_W'(CLK_HZ);
	localparam logic [ACC_W-1:0]  ACC_HALF      = ACC_W'(CLK_HZ / 32'h2);

	// ----------------------------------------------------------------
	// Control loop figures
	// ----------------------------------------------------------------
	localparam logic signed [PID_W-1:0] PID_OUTPUT_LIMIT = 18'sh04E20;
	localparam logic signed [PID_W-1:0] FREQ_KP          = 18'sh00001;
	localparam logic signed [PID_W-1:0] DUTY_KP          = 18'sh00001;
	localparam int FREQ_SCALE_HZ  = 32'sh1;
	localparam int DUTY_SCALE_LSB = 32'sh1;

	// ----------------------------------------------------------------
	// Timing, in microseconds and derived cycles
	// ----------------------------------------------------------------
	localparam int unsigned PING_WINDOW_US  = 32'h0001_1170;
	localparam int unsigned REPING_GAP_US   = 32'h0000_2710;
	localparam int unsigned PING_WINDOW_CYC = PING_WINDOW_US * (CLK_HZ / 32'h000F_4240);
	localparam int unsigned REPING_GAP_CYC  = REPING_GAP_US * (CLK_HZ / 32'h000F_4240);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] REG_TARGET  = 8'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 8'h08;
	localparam logic [ADDR_W-1:0] REG_FREQ    = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_DUTY    = 8'h10;
	localparam logic [ADDR_W-1:0] REG_CURRENT = 8'h14;
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_RETRY_BIT = 1;
	localparam int unsigned STAT_FAIL_BIT  = 4;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_PING = 4'h2,
		ST_GAP  = 4'h4,
		ST_XFER = 4'h8
	} pwr_state_t;

endpackage

// ===== rtl/wpt_freq_duty_power_control.sv
// Our own choices: the register offsets and register access over APB.
module wpt_freq_duty_power_control #(
	parameter int unsigned PING_CYC = pwr_ctrl_pkg::PING_WINDOW_CYC,
	parameter int unsigned GAP_CYC  = pwr_ctrl_pkg::REPING_GAP_CYC
) (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [pwr_ctrl_pkg::ADDR_W-1:0]      paddr,
	input  wire logic [31:0]                          pwdata,
	output logic [31:0]                               prdata,
	output logic                                      pready,
	output logic                                      pslverr,
	input  wire logic                                 ss_received,
	input  wire logic                                 coil_current_valid,
	input  wire logic [pwr_ctrl_pkg::CUR_W-1:0]       coil_current_ma,
	output logic                                      drive_a,
	output logic                                      drive_b,
	output logic                                      power_on
);
	import pwr_ctrl_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pwr_state_t              st;
		logic [ACC_W-1:0]        acc;
		logic [FREQ_W-1:0]       inverter_switching_frequency;
		logic [DUTY_W-1:0]       duty;
		logic [TMR_W-1:0]        timer;
		logic                    ctrl_en;
		logic                    ctrl_retry;
		logic                    ping_fail;
		logic [CUR_W-1:0]        target;
		logic [CUR_W-1:0]        cur;
		logic                    vld_s1;
		logic                    vld_s2;
		logic                    vld_s3;
		logic                    vld_lvl;
		logic                    err_vld;
		logic signed [PID_W-1:0] err;
		logic                    drv_a;
		logic                    drv_b;
		logic                    pwr;
		logic [31:0]             rdata;
		logic                    rdy;
		logic                    slverr;
	} ctl_t;

	localparam ctl_t CTL_RST = '{st: ST_IDLE, default: '0};

	ctl_t q, d;

	logic                    f_vld;
	logic                    d_vld;
	logic signed [PID_W-1:0] f_out;
	logic signed [PID_W-1:0] d_out;

	// ----------------------------------------------------------------
	// Control loops
	// ----------------------------------------------------------------
	pid_step #(.KP(FREQ_KP)) u_freq_pid (
		.pclk    (pclk),
		.presetn (presetn),
		.err_vld (q.err_vld),
		.err     (q.err),
		.out_vld (f_vld),
		.out     (f_out)
	);

	pid_step #(.KP(DUTY_KP)) u_duty_pid (
		.pclk    (pclk),
		.presetn (presetn),
		.err_vld (q.err_vld),
		.err     (q.err),
		.out_vld (d_vld),
		.out     (d_out)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic                    wr;
	logic                    rise;
	logic                    mapped;
	logic signed [FREQ_W+1:0] ftmp;
	logic signed [DUTY_W+9:0] dtmp;
	logic [ACC_W-1:0]        thr;
	logic [ACC_W:0]          asum;

	always_comb begin
		wr     = 1'b0;
		rise   = 1'b0;
		mapped = 1'b0;
		ftmp   = '0;
		dtmp   = '0;
		thr    = '0;
		asum   = '0;
		d      = q;

		// Current sample strobe crosses in from the converter's domain.
		d.vld_s1 = coil_current_valid;
		d.vld_s2 = q.vld_s1;
		d.vld_s3 = q.vld_s2;
		if (q.vld_s2 == q.vld_s3) begin
			d.vld_lvl = q.vld_s3;
			rise      = q.vld_s3 && !q.vld_lvl;
		end
		d.err_vld = 1'b0;
		if (rise) begin
			d.cur = coil_current_ma;
		end
		if (rise && q.st == ST_XFER) begin
			d.err_vld = 1'b1;
			d.err = $signed({2'b00, q.target}) - $signed({2'b00, coil_current_ma});
		end

		// APB slave, one answer cycle after setup.
		d.rdy    = psel && !penable && !q.rdy;
		d.slverr = 1'b0;
		d.rdata  = '0;
		case (paddr)
			REG_CTRL: begin
				mapped  = 1'b1;
				d.rdata = {30'h0, q.ctrl_retry, q.ctrl_en};
			end
			REG_TARGET: begin
				mapped  = 1'b1;
				d.rdata = {16'h0, q.target};
			end
			REG_STATUS: begin
				mapped  = 1'b1;
				d.rdata = {27'h0, q.ping_fail, q.st};
			end
			REG_FREQ: begin
				mapped  = 1'b1;
				d.rdata = {14'h0, q.inverter_switching_frequency};
			end
			REG_DUTY: begin
				mapped  = 1'b1;
				d.rdata = {22'h0, q.duty};
			end
			REG_CURRENT: begin
				mapped  = 1'b1;
				d.rdata = {16'h0, q.cur};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
		if (!(psel && !penable && !q.rdy)) begin
			d.rdata = q.rdata;
		end else begin
			d.slverr = !mapped;
		end
		wr = psel && penable && q.rdy && pwrite;
		if (wr && paddr == REG_CTRL) begin
			d.ctrl_en    = pwdata[CTRL_EN_BIT];
			d.ctrl_retry = pwdata[CTRL_RETRY_BIT];
			if (pwdata[CTRL_EN_BIT]) begin
				d.ping_fail = 1'b0;
			end
		end
		if (wr && paddr == REG_TARGET) begin
			d.target = pwdata[CUR_W-1:0];
		end

		// Power sequence.
		case (q.st)
			ST_IDLE: begin
				if (q.ctrl_en) begin
					d.st = ST_PING;
					d.inverter_switching_frequency = FREQ_PING_HZ;
					d.duty  = DUTY_PING;
					d.timer = TMR_W'(PING_CYC);
				end
			end
			ST_PING: begin
				d.timer = q.timer - 1'b1;
				if (!q.ctrl_en) begin
					d.st = ST_IDLE;
				end else if (ss_received) begin
					d.st = ST_XFER;
				end else if (q.timer == '0) begin
					if (q.ctrl_retry && q.duty < DUTY_MAX) begin
						d.st    = ST_GAP;
						d.timer = TMR_W'(GAP_CYC);
						d.duty  = (q.duty > DUTY_MAX - DUTY_STEP) ? DUTY_MAX : q.duty + DUTY_STEP;
					end else begin
						d.st        = ST_IDLE;
						d.ctrl_en   = 1'b0;
						d.ping_fail = 1'b1;
					end
				end
			end
			ST_GAP: begin
				d.timer = q.timer - 1'b1;
				if (!q.ctrl_en) begin
					d.st = ST_IDLE;
				end else if (q.timer == '0) begin
					d.st    = ST_PING;
					d.timer = TMR_W'(PING_CYC);
				end
			end
			ST_XFER: begin
				if (!q.ctrl_en) begin
					d.st = ST_IDLE;
				end else if (f_vld && d_vld) begin
					// Frequency and duty both take the full correction, duty in tenth-percent steps and in the opposite sense.
					ftmp = $signed({2'b00, q.inverter_switching_frequency})
						+ $signed(FREQ_SCALE_HZ[1:0]) * $signed({{2{f_out[PID_W-1]}}, f_out});
					dtmp = $signed({10'h000, q.duty})
						- $signed(DUTY_SCALE_LSB[1:0]) * $signed({{2{d_out[PID_W-1]}}, d_out});
					if (ftmp > $signed({2'b00, FREQ_MAX_HZ})) begin
						d.inverter_switching_frequency = FREQ_MAX_HZ;
					end else if (ftmp < $signed({2'b00, FREQ_MIN_HZ})) begin
						d.inverter_switching_frequency = FREQ_MIN_HZ;
					end else begin
						d.inverter_switching_frequency = ftmp[FREQ_W-1:0];
					end
					if (dtmp > $signed({10'h000, DUTY_MAX})) begin
						d.duty = DUTY_MAX;
					end else if (dtmp < $signed({10'h000, DUTY_MIN})) begin
						d.duty = DUTY_MIN;
					end else begin
						d.duty = dtmp[DUTY_W-1:0];
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
			end
		endcase

		// Bridge drive: exact frequency from a modulo-clock accumulator.
		// Each leg conducts for duty of a period, the second leg half a period later.
		d.pwr = (q.st == ST_PING) || (q.st == ST_XFER);
		if (q.pwr) begin
			asum = {1'b0, q.acc} + {8'h00, q.inverter_switching_frequency};
			if (asum >= {1'b0, ACC_WRAP}) begin
				asum = asum - {1'b0, ACC_WRAP};
			end
			d.acc = asum[ACC_W-1:0];
		end else begin
			d.acc = '0;
		end
		thr     = ACC_W'(q.duty * DUTY_UNIT_CYC);
		d.drv_a = q.pwr && (q.acc < thr);
		d.drv_b = q.pwr && (q.acc >= ACC_HALF) && (q.acc < ACC_HALF + thr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= CTL_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata   = q.rdata;
	assign pready   = q.rdy;
	assign pslverr  = q.slverr;
	assign drive_a  = q.drv_a;
	assign drive_b  = q.drv_b;
	assign power_on = q.pwr;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_freq_range;
		power_on |-> q.inverter_switching_frequency >= FREQ_MIN_HZ
			&& q.inverter_switching_frequency <= FREQ_MAX_HZ;
	endproperty
	a_freq_range: assert property (p_freq_range) else $error("frequency out of range");

	property p_duty_range;
		power_on |-> q.duty >= DUTY_MIN && q.duty <= DUTY_MAX;
	endproperty
	a_duty_range: assert property (p_duty_range) else $error("duty out of range");

	property p_ping_start;
		q.st == ST_IDLE && q.ctrl_en |=> q.st == ST_PING
			&& q.inverter_switching_frequency == FREQ_PING_HZ && q.duty == DUTY_PING ##1 power_on;
	endproperty
	a_ping_start: assert property (p_ping_start) else $error("ping not at start point");

	sequence s_ping_expired;
		q.st == ST_PING && q.ctrl_en && !ss_received && q.timer == '0;
	endsequence

	property p_ping_off;
		s_ping_expired ##0 !(q.ctrl_retry && q.duty < DUTY_MAX)
			|=> q.ping_fail ##1 !power_on ##1 !drive_a && !drive_b;
	endproperty
	a_ping_off: assert property (p_ping_off) else $error("power left on after ping");

	property p_retry;
		s_ping_expired ##0 q.ctrl_retry && q.duty < DUTY_MAX
			|=> q.st == ST_GAP && q.duty > $past(q.duty) ##1 !power_on;
	endproperty
	a_retry: assert property (p_retry) else $error("retry duty not raised");

	property p_freq_up;
		// The bound keeps a full-size step clear of the upper clamp.
		q.st == ST_XFER && q.ctrl_en && f_vld && d_vld && f_out > 0
			&& q.inverter_switching_frequency <= FREQ_MAX_HZ - FREQ_W'(PID_OUTPUT_LIMIT)
		|=> q.inverter_switching_frequency == $past(q.inverter_switching_frequency)
			+ FREQ_W'($past(f_out));
	endproperty
	a_freq_up: assert property (p_freq_up) else $error("frequency step wrong");

	property p_duty_down;
		q.st == ST_XFER && q.ctrl_en && d_vld && d_out > 0 && q.duty > DUTY_MIN
		|=> q.duty < $past(q.duty);
	endproperty
	a_duty_down: assert property (p_duty_down) else $error("duty moved the wrong way");

	property p_sample;
		q.st == ST_XFER && q.vld_s2 && q.vld_s3 && !q.vld_lvl
		|=> q.err_vld && q.cur == $past(coil_current_ma) ##1 f_vld && d_vld;
	endproperty
	a_sample: assert property (p_sample) else $error("current sample not used");

endmodule

// ===== verif/rx_partner.sv
// --------
// Receiver model: answers a ping and reports the coil current.
// --------
module rx_partner #(
	parameter int unsigned ANS_DLY = 20
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      power_on,
	input  wire logic                      arm,
	input  wire logic [3:0]                skip,
	output logic                           ss_received,
	output logic                           coil_current_valid,
	output logic [pwr_ctrl_pkg::CUR_W-1:0] coil_current_ma
);
	timeunit 1ns;
	timeprecision 1ns;
	import pwr_ctrl_pkg::*;

	logic       pwr_q;
	logic [3:0] ping_q;
	logic [7:0] wait_q;

	initial begin
		coil_current_valid = 1'b0;
		coil_current_ma    = '0;
	end

	// With arm low the receiver stays silent, so a ping can be left unanswered.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_q       <= 1'b0;
			ping_q      <= 4'h0;
			wait_q      <= 8'h00;
			ss_received <= 1'b0;
		end else begin
			pwr_q       <= power_on;
			ss_received <= arm && power_on && ping_q > skip && wait_q == 8'(ANS_DLY);
			wait_q      <= !power_on ? 8'h00 : (wait_q == 8'hFF ? wait_q : wait_q + 8'h01);
			if (!arm)
				ping_q <= 4'h0;
			else if (power_on && !pwr_q)
				ping_q <= ping_q + 4'h1;
		end
	end

	// Data is held past the four cycles the sampler needs, then scrambled.
	task automatic send(input logic [CUR_W-1:0] ma);
		coil_current_ma    <= ma;
		coil_current_valid <= 1'b1;
		repeat (6) @(posedge pclk);
		coil_current_valid <= 1'b0;
		coil_current_ma    <= ~ma;
		repeat (12) @(posedge pclk);
	endtask
endmodule

// ===== verif/test_wpt_freq_duty_power_control.sv
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (a), (e)); end end

module test_wpt_freq_duty_power_control;
	timeunit 1ns;
	timeprecision 1ns;
	import pwr_ctrl_pkg::*;

	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              ss_received;
	logic              coil_current_valid;
	logic [CUR_W-1:0]  coil_current_ma;
	logic              drive_a;
	logic              drive_b;
	logic              power_on;
	logic              arm;
	logic [3:0]        skip;
	int                error_cnt;
	int                cmp_count;

	// The ping is shortened so that a few drive periods still fit in it.
	wpt_freq_duty_power_control #(
		.PING_CYC (400),
		.GAP_CYC  (20)
	) wpt_freq_duty_power_control_i (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.prdata             (prdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.ss_received        (ss_received),
		.coil_current_valid (coil_current_valid),
		.coil_current_ma    (coil_current_ma),
		.drive_a            (drive_a),
		.drive_b            (drive_b),
		.power_on           (power_on)
	);

	rx_partner rx_partner_i (
		.pclk               (pclk),
		.presetn            (presetn),
		.power_on           (power_on),
		.arm                (arm),
		.skip               (skip),
		.ss_received        (ss_received),
		.coil_current_valid (coil_current_valid),
		.coil_current_ma    (coil_current_ma)
	);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	// --------
	// Bus and measurement tasks.
	// --------
	task automatic final_report();
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			error_cnt++;
			final_report();
		end
		@(posedge pclk);
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'b1, a, v, d, e);
	endtask

	task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		`CHK({e, d}, {1'b0, v});
	endtask

	task automatic wait_state(input logic [3:0] st);
		int          n;
		logic [31:0] d;
		logic        e;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0, d, e);
			n++;
		end while (d[3:0] !== st && n < 400);
		if (d[3:0] !== st) begin
			error_cnt++;
			final_report();
		end
	endtask

	// Period of leg A and high time of both legs, in cycles, from one rise of A to the next.
	task automatic measure(output int per, output int hi, output int hb);
		int n;
		bit seen;
		n    = 0;
		per  = 0;
		hi   = 0;
		hb   = 0;
		seen = 1'b0;
		while (drive_a !== 1'b0 && n < 999) begin
			@(posedge pclk);
			n++;
		end
		while (drive_a !== 1'b1 && n < 999) begin
			@(posedge pclk);
			n++;
		end
		while (!(seen && drive_a === 1'b1) && per < 999) begin
			hi   += (drive_a === 1'b1) ? 1 : 0;
			hb   += (drive_b === 1'b1) ? 1 : 0;
			seen |= (drive_a === 1'b0);
			per++;
			@(posedge pclk);
		end
		if (n >= 999 || per >= 999) begin
			error_cnt++;
			final_report();
		end
	endtask

	function automatic int clip(int v, int lo, int hi);
		return v < lo ? lo : (v > hi ? hi : v);
	endfunction

	initial begin
		repeat (100000) @(posedge pclk);
		error_cnt++;
		final_report();
	end

	// --------
	// Main sequence.
	// --------
	initial begin
		logic [31:0] d;
		logic        e;
		int          per;
		int          hi;
		int          hb;
		int          f;
		int          u;
		int          o;
		int          tv[4] = '{256, 30000, 0, 30000};
		int          cv[4] = '{128, 0, 60000, 0};
		int          rp[4] = '{1, 1, 6, 6};
		error_cnt = 0;
		cmp_count = 0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = '0;
		pwdata    = 32'h0;
		arm       = 1'b0;
		skip      = 4'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(REG_CTRL, 32'h0);
		rd_chk(REG_STATUS, 32'h1);
		wr(REG_FREQ, 32'h0000_1234);
		rd_chk(REG_FREQ, 32'h0);
		apb(1'b0, 8'h18, 32'h0, d, e);
		`CHK({e, d}, 33'h1_0000_0000);
		// A silent receiver gets one ping, then the drive is removed.
		wr(REG_CTRL, 32'h1);
		wait_state(4'h2);
		rd_chk(REG_FREQ, 32'(FREQ_PING_HZ));
		rd_chk(REG_DUTY, 32'(DUTY_PING));
		measure(per, hi, hb);
		`CHK(per inside {[153:154]}, 1'b1);
		`CHK(hi inside {[37:40]}, 1'b1);
		`CHK(hb inside {[37:40]}, 1'b1);
		wait_state(4'h1);
		`CHK({power_on, drive_a, drive_b}, 3'b000);
		rd_chk(REG_STATUS, 32'h11);
		rd_chk(REG_CTRL, 32'h0);
		// Only the second ping is answered, after a gap and one duty step.
		arm  <= 1'b1;
		skip <= 4'h1;
		wr(REG_CTRL, 32'h3);
		rd_chk(REG_STATUS, 32'h2);
		wait_state(4'h4);
		`CHK(power_on, 1'b0);
		wait_state(4'h8);
		rd_chk(REG_DUTY, 32'(DUTY_PING + DUTY_STEP));
		// Samples drive both variables into their limits at each end.
		f = int'(FREQ_PING_HZ);
		u = int'(DUTY_PING + DUTY_STEP);
		foreach (tv[k]) begin
			wr(REG_TARGET, 32'(tv[k]));
			repeat (rp[k]) begin
				rx_partner_i.send(CUR_W'(cv[k]));
				o = clip(tv[k] - cv[k], -int'(PID_OUTPUT_LIMIT), int'(PID_OUTPUT_LIMIT));
				f = clip(f + o, int'(FREQ_MIN_HZ), int'(FREQ_MAX_HZ));
				u = clip(u - o, int'(DUTY_MIN), int'(DUTY_MAX));
				rd_chk(REG_FREQ, 32'(f));
				rd_chk(REG_DUTY, 32'(u));
				rd_chk(REG_CURRENT, 32'(cv[k]));
			end
		end
		measure(per, hi, hb);
		`CHK(per inside {[97:98]}, 1'b1);
		`CHK(hi inside {[1:2]}, 1'b1);
		`CHK(hb inside {[1:2]}, 1'b1);
		// Outside transfer a sample is only recorded.
		wr(REG_CTRL, 32'h0);
		wait_state(4'h1);
		`CHK(power_on, 1'b0);
		rx_partner_i.send(16'h1234);
		rd_chk(REG_CURRENT, 32'h0000_1234);
		rd_chk(REG_FREQ, 32'(f));
		final_report();
	end
endmodule
